// ==== dv/bobwd_assertions.sv ====
// Checker for burst sequencing and lane decode
`timescale 1ns/1ps
module bobwd_assertions
  import bobwd_pkg::*;
(
  input wire logic mclk_in,
  input wire logic resetn_in,
  input wire logic clock_qualify_n_in,
  input wire logic chip_sel_in,
  input wire logic advance_or_load_in,
  input wire logic write_n_in,
  input wire logic [16:0] addr_in,
  input wire logic [3:0] byte_lane_select_n_in,
  input wire logic [31:0] data_in,
  input wire logic [3:0] parity_io_in,
  input wire logic burst_order_in,
  input wire logic [16:0] beat_addr_out,
  input wire logic beat_read_out,
  input wire bobwd_wr_t wr_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!resetn_in);
  wire logic go = !clock_qualify_n_in;
  wire logic ad = advance_or_load_in;
  wire logic rb = beat_read_out;
  wire logic [3:0] le = wr_out.lane_en;
  wire logic [1:0] lo = beat_addr_out[1:0];
  logic [1:0] st_q;
  always_ff @(posedge mclk_in) if (go && !ad) st_q <= addr_in[1:0];
  a_read_load: assert property (
    $past(go && !ad && chip_sel_in && write_n_in) |-> rb && beat_addr_out == $past(addr_in))
    else $error("read load");
  a_write_latch: assert property (
    $past(go && !ad && chip_sel_in && !write_n_in, 2) && $past(go)
    |-> wr_out.valid && wr_out.addr == $past(addr_in, 2)) else $error("write latch");
  a_lane_map: assert property (
    wr_out.valid |-> le == ~$past(byte_lane_select_n_in)) else $error("lane map");
  a_lane_data: assert property (wr_out.valid |->
    wr_out.data == ($past(data_in) & {{8{le[3]}}, {8{le[2]}}, {8{le[1]}}, {8{le[0]}}})
    && wr_out.parity == ($past(parity_io_in) & le)) else $error("lane data");
  a_linear_step: assert property (
    rb && $past(rb && ad) && !burst_order_in && !$past(burst_order_in, 6)
    |-> lo == $past(lo) + 2'h1) else $error("linear step");
  a_ilv_step: assert property (
    rb && $past(rb && ad) && burst_order_in && $past(burst_order_in, 6)
    |-> (lo ^ st_q) == ($past(lo) ^ st_q) + 2'h1) else $error("interleave step");
  a_upper_hold: assert property (
    rb && $past(rb && ad) |-> beat_addr_out[16:2] == $past(beat_addr_out[16:2]))
    else $error("upper bits");
  a_count_wrap: assert property (
    rb && $past(rb && ad) && $past(rb && ad, 2) |-> lo == ($past(lo, 2) ^ 2'h2))
    else $error("wrap");
endmodule
bind bobwd_core bobwd_assertions u_chk (.*);

// ==== dv/bobwd_ctl_model.sv ====
// Memory controller model that drives the sequencer pins
`timescale 1ns/1ps
module bobwd_ctl_model (
  input wire logic mclk_in,
  output logic qual_n_out,
  output logic cs_out,
  output logic adv_out,
  output logic wn_out,
  output logic [16:0] addr_out,
  output logic [3:0] lanes_n_out,
  output logic [31:0] data_out,
  output logic [3:0] par_out,
  output logic mode_out
);
  initial {qual_n_out, cs_out, adv_out, wn_out, addr_out, lanes_n_out, data_out, par_out,
    mode_out} = {1'b1, 61'h0};
  // Changes only at the falling edge
  task automatic drive(input logic [61:0] v);
    @(negedge mclk_in);
    {qual_n_out, cs_out, adv_out, wn_out, addr_out, lanes_n_out, data_out, par_out,
      mode_out} = v;
  endtask
endmodule

// ==== dv/tb_top.sv ====
// Self-checking bench for the burst sequencer
`timescale 1ns/1ps
module tb_top
  import bobwd_pkg::*;
;
  logic mclk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic clock_qualify_n_in, chip_sel_in, advance_or_load_in, write_n_in, burst_order_in;
  logic [16:0] addr_in, beat_addr_out, base, pa;
  logic [3:0] byte_lane_select_n_in, parity_io_in;
  logic [31:0] data_in;
  logic beat_read_out, pend = 1'b0, md = 1'b0;
  logic [1:0] op = 2'h0, cnt;
  bobwd_wr_t wr_out;
  int seed = 32'h3966;
  int error_cnt = 0;
  int check_count = 0;
  logic [16:0] rdq[$];
  bobwd_wr_t wrq[$];
  always #2.5 mclk_in = ~mclk_in;
  bobwd_core u_dut (.*);
  bobwd_ctl_model u_ctl (.mclk_in(mclk_in), .qual_n_out(clock_qualify_n_in),
    .cs_out(chip_sel_in), .adv_out(advance_or_load_in), .wn_out(write_n_in),
    .addr_out(addr_in), .lanes_n_out(byte_lane_select_n_in), .data_out(data_in),
    .par_out(parity_io_in), .mode_out(burst_order_in));
  task automatic fail(string s);
    error_cnt++;
    $display("[ERR] %0t %s", $time, s);
  endtask
  // Drive one cycle and note what it must produce
  task automatic step(logic q, s, adv, w, logic [3:0] l);
    logic [16:0] a = 17'($random(seed));
    logic [31:0] d = $random(seed);
    logic [3:0] p = 4'($random(seed));
    logic [3:0] m = ~l;
    u_ctl.drive({~q, s, adv, w, a, l, d, p, md});
    if (!q) return;
    if (pend) wrq.push_back({1'b1, pa, m, d & {{8{m[3]}}, {8{m[2]}}, {8{m[1]}}, {8{m[0]}}}, p & m});
    pend = 1'b0;
    if (!adv) begin
      op = !s ? 2'h0 : w ? 2'h1 : 2'h2;
      base = a;
      cnt = 2'h0;
    end else cnt++;
    pa = {base[16:2], md ? base[1:0] ^ cnt : base[1:0] + cnt};
    if (op == 2'h1) rdq.push_back(pa);
    pend = op == 2'h2;
  endtask
  task automatic check_read(logic [16:0] got);
    check_count++;
    if (rdq.size() == 0) fail("unexpected read beat");
    else if (got !== rdq.pop_front()) fail("read addr");
  endtask
  task automatic check_write(bobwd_wr_t got);
    check_count++;
    if (wrq.size() == 0) fail("unexpected write beat");
    else if (got !== wrq.pop_front()) fail("write beat");
  endtask
  always @(negedge mclk_in) if (resetn_in) begin
    if ($isunknown({beat_read_out, wr_out.valid})) fail("unknown beat strobe");
    if (beat_read_out === 1'b1) check_read(beat_addr_out);
    if (wr_out.valid === 1'b1) check_write(wr_out);
  end
  task automatic results();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    #20000 fail("timeout");
    results();
  end
  initial begin
    repeat (20) @(negedge mclk_in);
    resetn_in = 1'b1;
    for (int i = 0; i < 2; i++) begin
      md = i[0];
      repeat (8) step(1, 0, 0, 1, 4'h0);
      for (int k = 0; k < 20; k++) step(1, 1, k % 5 != 0, 1, 4'($random(seed)));
      for (int k = 0; k < 17; k++) step(1, 1, k % 4 != 0, 0, 4'(k - 1));
      step(0, 1, 1, 0, 4'h0);
      step(1, 0, 0, 1, 4'h3);
      repeat (3) step(1, 0, 0, 1, 4'h0);
      step(1, 1, 1, 0, 4'h0);
      $display("mode %0d done", i);
    end
    if (rdq.size() + wrq.size() != 0) fail("beats missing");
    results();
  end
endmodule

// ==== rtl/bobwd_core.sv ====
// Burst address sequencer and byte-lane write decode
// Summary of operation
// - Interleaved order gives beats two to four as the start bits XOR 01, 10 and 11.
// - Linear order adds one to the low two bits each beat, wrapping 11 to 00.
// - A high write strobe means a read and all byte-lane selects are ignored.
// - A low write strobe with all lane selects high is a write that changes no byte.
// - Lane select zero low writes data bits 7..0 and parity bit 0.
// - Lane select one low writes data bits 15..8 and parity bit 1.
// - Lane select two low writes data bits 23..16 and parity bit 2.
// - Lane select three low writes bits 31..24 and parity bit 3, any lane mix allowed.
// - Burst order select low means linear order, high means interleaved.
// - The burst counter covers only the two low address bits and wraps, four beats a load.
// - Write data and lane selects are taken on the next qualified edge after the write command.
`timescale 1ns/1ps
module bobwd_core
  import bobwd_pkg::*;
(
  input wire logic mclk_in,
  input wire logic resetn_in,
  input wire logic clock_qualify_n_in,
  input wire logic chip_sel_in,
  input wire logic advance_or_load_in,
  input wire logic write_n_in,
  input wire logic [BOBWD_ADDR_W-1:0] addr_in,
  input wire logic [BOBWD_LANES-1:0] byte_lane_select_n_in,
  input wire logic [BOBWD_DATA_W-1:0] data_in,
  input wire logic [BOBWD_LANES-1:0] parity_io_in,
  input wire logic burst_order_in,
  output logic [BOBWD_ADDR_W-1:0] beat_addr_out,
  output logic beat_read_out,
  output bobwd_wr_t wr_out
);
  // ---------------------------------------------------------------
  // Mode strap synchroniser
  // ---------------------------------------------------------------
  logic interleave;

  bobwd_sync u_mode_sync (
    .mclk_in(mclk_in),
    .resetn_in(resetn_in),
    .pin_in(burst_order_in),
    .level_out(interleave)
  );

  // ---------------------------------------------------------------
  // Burst sequence function
  // ---------------------------------------------------------------
  function automatic logic [1:0] burst_bits(input logic [1:0] start, input logic [1:0] cnt,
                                            input logic ilv);
    logic [1:0] res;
    if (ilv) begin
      res = start ^ cnt;
    end else begin
      res = start + cnt;
    end
    return res;
  endfunction

  // Deselect on a load gives an idle burst with no beats
  function automatic bobwd_op_t load_op(input logic sel, input logic wr_n);
    bobwd_op_t res;
    if (!sel) begin
      res = BOBWD_IDLE;
    end else if (wr_n) begin
      res = BOBWD_READ;
    end else begin
      res = BOBWD_WRITE;
    end
    return res;
  endfunction

  // ---------------------------------------------------------------
  // Command decode
  // ---------------------------------------------------------------
  logic cmd_take;
  logic cmd_load;
  bobwd_op_t cmd_op;

  // A high qualify input holds burst, address and pending-write state; read and write beat strobes clear
  assign cmd_take = !clock_qualify_n_in;
  assign cmd_load = cmd_take && !advance_or_load_in;
  assign cmd_op = load_op(chip_sel_in, write_n_in);

  // ---------------------------------------------------------------
  // Burst state
  // ---------------------------------------------------------------
  bobwd_op_t op_q;
  bobwd_op_t op_d;
  logic [BOBWD_ADDR_W-1:0] base_q;
  logic [BOBWD_ADDR_W-1:0] base_d;
  logic [1:0] cnt_q;
  logic [1:0] cnt_d;
  logic [BOBWD_ADDR_W-1:0] cur_addr;

  always_comb begin
    op_d = op_q;
    base_d = base_q;
    cnt_d = cnt_q;
    cur_addr = base_q;
    if (cmd_load) begin
      op_d = cmd_op;
      base_d = addr_in;
      cnt_d = 2'h0;
      cur_addr = addr_in;
    end else if (cmd_take) begin
      // Selects and strobe are ignored; the count wraps after four beats
      cnt_d = cnt_q + BOBWD_STEP_ONE;
      cur_addr = {base_q[BOBWD_ADDR_W-1:BOBWD_BURST_W],
                  burst_bits(base_q[1:0], cnt_d, interleave)};
    end
  end

  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      op_q <= BOBWD_IDLE;
      base_q <= '0;
      cnt_q <= BOBWD_SYNC_RESET;
    end else begin
      op_q <= op_d;
      base_q <= base_d;
      cnt_q <= cnt_d;
    end
  end

  // ---------------------------------------------------------------
  // Beat address and pending data phase
  // ---------------------------------------------------------------
  logic [BOBWD_ADDR_W-1:0] addr_q;
  logic [BOBWD_ADDR_W-1:0] addr_d;
  logic rd_q;
  logic rd_d;
  logic wr_pend_q;
  logic wr_pend_d;
  logic [BOBWD_ADDR_W-1:0] wr_addr_q;
  logic [BOBWD_ADDR_W-1:0] wr_addr_d;

  always_comb begin
    // Suspended cycles hold the pending data phase
    addr_d = addr_q;
    rd_d = 1'b0;
    wr_pend_d = wr_pend_q;
    wr_addr_d = wr_addr_q;
    if (cmd_take) begin
      // Reads answer with the beat address one edge later
      addr_d = cur_addr;
      rd_d = (op_d == BOBWD_READ);
      // Data for a write beat comes one qualified edge later
      wr_pend_d = (op_d == BOBWD_WRITE);
      wr_addr_d = cur_addr;
    end
  end

  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      addr_q <= '0;
      rd_q <= 1'b0;
      wr_pend_q <= 1'b0;
      wr_addr_q <= '0;
    end else begin
      addr_q <= addr_d;
      rd_q <= rd_d;
      wr_pend_q <= wr_pend_d;
      wr_addr_q <= wr_addr_d;
    end
  end

  // ---------------------------------------------------------------
  // Per-lane write decode
  // ---------------------------------------------------------------
  logic [BOBWD_LANES-1:0] lane_hit;
  logic [BOBWD_DATA_W-1:0] lane_data;
  logic [BOBWD_LANES-1:0] lane_par;
  logic lanes_none;

  // Lanes not selected stay zero so stale bytes never leak out
  for (genvar g = 0; g < BOBWD_LANES; g++) begin : g_lane
    assign lane_hit[g] = !byte_lane_select_n_in[g];
    assign lane_data[g*BOBWD_LANE_W +: BOBWD_LANE_W] =
      lane_hit[g] ? data_in[g*BOBWD_LANE_W +: BOBWD_LANE_W] : '0;
    assign lane_par[g] = lane_hit[g] & parity_io_in[g];
  end

  // All selects high: a write that stores nothing
  assign lanes_none = (byte_lane_select_n_in == BOBWD_LANES_NONE_N);

  // ---------------------------------------------------------------
  // Write beat register
  // ---------------------------------------------------------------
  bobwd_wr_t wr_q;
  bobwd_wr_t wr_d;

  always_comb begin
    wr_d = '0;
    if (cmd_take && wr_pend_q) begin
      wr_d.valid = 1'b1;
      wr_d.addr = wr_addr_q;
      wr_d.lane_en = lane_hit;
      wr_d.data = lane_data;
      wr_d.parity = lane_par;
      // Empty lane mask still counts as a write beat
      if (lanes_none) begin
        wr_d.lane_en = '0;
      end
    end
  end

  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      wr_q <= '0;
    end else begin
      wr_q <= wr_d;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign wr_out = wr_q;
  assign beat_addr_out = addr_q;
  assign beat_read_out = rd_q;
endmodule

// ==== rtl/bobwd_sync.sv ====
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module bobwd_sync (
  input wire logic mclk_in,
  input wire logic resetn_in,
  input wire logic pin_in,
  output logic level_out
);
  logic [2:0] sync_q;
  logic [2:0] sync_d;
  logic level_q;
  logic level_d;

  always_comb begin
    sync_d = {sync_q[1:0], pin_in};
    level_d = (sync_q[1] == sync_q[2]) ? sync_q[2] : level_q;
  end

  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      sync_q <= 3'h0;
      level_q <= 1'b0;
    end else begin
      sync_q <= sync_d;
      level_q <= level_d;
    end
  end

  assign level_out = level_q;
endmodule

// ==== shared/bobwd_pkg.sv ====
// Package for the burst address sequencer and byte-lane write decode
package bobwd_pkg;
  localparam int BOBWD_ADDR_W = 17;
  localparam int BOBWD_LANES = 4;
  localparam int BOBWD_LANE_W = 8;
  localparam int BOBWD_DATA_W = BOBWD_LANES * BOBWD_LANE_W;
  localparam int BOBWD_BURST_W = 2;
  localparam logic [1:0] BOBWD_BURST_LAST = 2'h3;
  localparam logic [1:0] BOBWD_STEP_ONE = 2'h1;
  localparam logic [3:0] BOBWD_LANES_NONE_N = 4'hf;
  localparam logic [1:0] BOBWD_SYNC_RESET = 2'h0;

  typedef enum logic [1:0] {
    BOBWD_IDLE = 2'b00,
    BOBWD_READ = 2'b01,
    BOBWD_WRITE = 2'b10
  } bobwd_op_t;

  // One write beat to the storage array
  typedef struct packed {
    logic valid;
    logic [BOBWD_ADDR_W-1:0] addr;
    logic [BOBWD_LANES-1:0] lane_en;
    logic [BOBWD_DATA_W-1:0] data;
    logic [BOBWD_LANES-1:0] parity;
  } bobwd_wr_t;
endpackage
